// >>> sim/ecc_error_trap_and_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eet_params.svh"
// ----
// Bench top
// ----
module ecc_error_trap_and_counter_tb_top
  import eet_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        clr_cmd = 1'b0;
  logic        sw_rst  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd, trap, a;
  logic [15:0] tally;
  logic        pready, pslverr, irq, se;
  wire logic   rda, uv, es, ed;
  wire logic [31:0] ua;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #20 sys_clk = ~sys_clk;
  eet_read_src src (.sys_clk(sys_clk), .read_active(rda), .unit_valid(uv),
    .unit_byte_addr(ua), .err_single(es), .err_double(ed));
  eet_trap DUT (.sys_clk(sys_clk), .rst_n(rst_n), .read_active(rda), .unit_valid(uv),
    .unit_byte_addr(ua), .err_single(es), .err_double(ed),
    .clear_ecc_status_command(clr_cmd), .soft_reset(sw_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trapped_unit_address(trap), .error_tally_value(tally), .irq(irq));
  function automatic logic [31:0] unit_of(input logic [31:0] x);
    return {x[31:4], 4'h0};
  endfunction : unit_of
  task check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, s, e);
    end
  endtask : check
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h42bd));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, `EET_OFS_ADDR, 32'h0);
    check(rd, `EET_TRAP_RESET);
    apb(1'b0, `EET_OFS_TALLY, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    check({31'h0, se}, 32'h1);
    apb(1'b1, `EET_OFS_IRQEN, 32'h7);
    src.burst(32'h40, 1'b1, 1'b1, 1);
    apb(1'b0, `EET_OFS_TALLY, 32'h0);
    check(rd, 32'h0);
    check(trap, 32'h0);
    src.set_read(1'b1);
    src.burst(32'h0, 1'b1, 1'b0, 1);
    a = $urandom;
    src.burst(a, 1'b0, 1'b1, 2);
    apb(1'b0, `EET_OFS_TALLY, 32'h0);
    check(rd, 32'h3);
    check(trap, 32'h0);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, `EET_OFS_STAT, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, `EET_OFS_IRQCLR, 32'h7);
    repeat (2) @(negedge sys_clk);
    check({31'h0, irq}, 32'h0);
    @(posedge sys_clk);
    clr_cmd <= 1'b1;
    @(posedge sys_clk);
    clr_cmd <= 1'b0;
    a = $urandom;
    src.burst(a, 1'b1, 1'b0, 1);
    apb(1'b0, `EET_OFS_ADDR, 32'h0);
    check(rd, unit_of(a));
    check(rd & 32'h03ff_fff0, a & 32'h03ff_fff0);
    check({16'h0, tally}, 32'h4);
    apb(1'b1, `EET_OFS_CLEAR, 32'h1);
    apb(1'b0, `EET_OFS_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `EET_OFS_CTRL, 32'h1);
    src.burst(a, 1'b0, 1'b1, 1);
    src.burst(a + 32'h10, 1'b1, 1'b0, 1);
    apb(1'b0, `EET_OFS_TALLY, 32'h0);
    check(rd, 32'h5);
    check(trap, unit_of(a + 32'h10));
    apb(1'b1, `EET_OFS_CTRL, 32'h0);
    apb(1'b1, `EET_OFS_CLEAR, 32'h2);
    apb(1'b0, `EET_OFS_TALLY, 32'h0);
    check(rd, 32'h0);
    src.burst(a, 1'b1, 1'b1, 65537);
    apb(1'b0, `EET_OFS_TALLY, 32'h0);
    check(rd, {16'h0, `EET_TALLY_MAX});
    apb(1'b0, `EET_OFS_STAT, 32'h0);
    check(rd & 32'h4, 32'h4);
    @(posedge sys_clk);
    sw_rst <= 1'b1;
    @(posedge sys_clk);
    sw_rst <= 1'b0;
    @(negedge sys_clk);
    check({16'h0, tally}, 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(trap, 32'h0);
    check({16'h0, tally}, 32'h0);
    end_of_test();
  end
endmodule : ecc_error_trap_and_counter_tb_top
`default_nettype wire

// >>> sim/eet_read_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Read stream source
// ----
module eet_read_src
  import eet_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             read_active,
  output logic             unit_valid,
  output logic      [31:0] unit_byte_addr,
  output logic             err_single,
  output logic             err_double
);
  initial begin
    read_active = 1'b0;
    unit_valid = 1'b0;
    unit_byte_addr = 32'h0;
    err_single = 1'b0;
    err_double = 1'b0;
  end
  task set_read(input logic on);
    @(posedge sys_clk);
    read_active <= on;
    repeat (2) @(posedge sys_clk);
  endtask : set_read
  task burst(input logic [31:0] a, input logic s, input logic d, input int n);
    @(posedge sys_clk);
    unit_valid <= 1'b1;
    unit_byte_addr <= a;
    err_single <= s;
    err_double <= d;
    repeat (n) @(posedge sys_clk);
    unit_valid <= 1'b0;
    unit_byte_addr <= ~a;
    err_single <= ~s;
    err_double <= ~d;
  endtask : burst
endmodule : eet_read_src
`default_nettype wire

// >>> verilog/eet_error_qualify.sv
`timescale 1ns/1ps
`default_nettype none
`include "eet_params.svh"

module eet_error_qualify
  import eet_pkg::*;
(
  input  wire logic   one_bit_only,
  input  wire logic   unit_valid,
  input  wire logic   err_single,
  input  wire logic   err_double,
  input  wire logic   in_read,
  output logic        log_error
);
  // ---------------------------------------------------------------
  // Qualify one decoded unit for logging
  // ---------------------------------------------------------------
  always_comb begin
    log_error = unit_valid & in_read
              & (err_single | (err_double & ~one_bit_only));
  end
endmodule : eet_error_qualify
`default_nettype wire

// >>> verilog/eet_params.svh
`ifndef EET_PARAMS_SVH
`define EET_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define EET_OFS_ADDR   12'h000
`define EET_OFS_TALLY  12'h004
`define EET_OFS_CTRL   12'h008
`define EET_OFS_CLEAR  12'h00c
`define EET_OFS_STAT   12'h010
`define EET_OFS_IRQCLR 12'h014
`define EET_OFS_IRQEN  12'h018

// ---------------------------------------------------------------
// Field positions and values
// ---------------------------------------------------------------
`define EET_CTRL_ONEBIT_BIT  0
`define EET_CLEAR_TRAP_BIT   0
`define EET_CLEAR_SWRST_BIT  1
`define EET_EV_TRAP_BIT      0
`define EET_EV_COUNT_BIT     1
`define EET_EV_SAT_BIT       2
`define EET_TRAP_RESET       32'h0000_0000
`define EET_TALLY_RESET      16'h0000
`define EET_TALLY_MAX        16'hffff
`define EET_UNIT_LSB         4
`define EET_EV_W             3

`endif

// >>> verilog/eet_pkg.sv
package eet_pkg;
  typedef logic [31:0] eet_addr_t;
  typedef logic [15:0] eet_tally_t;
  typedef enum logic [1:0] {
    EET_IDLE  = 2'b01,
    EET_READ  = 2'b10
  } eet_mode_t;
endpackage : eet_pkg

// >>> verilog/eet_trap.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "eet_params.svh"

// What this block does
// - First read error loads unit address, held
// - Log single and double, or single only
// - Trap changes only during read instruction
// - Clear command, resets zero the trap
// - Sixteen bit count of read errors
// - Counter changes only during read instruction
// - At most one count per unit read
// - Counter saturates at all ones
// - Resets zero the counter
// - Each sixteen byte unit is one ECC unit
module eet_trap
  import eet_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        read_active,
  input  wire logic        unit_valid,
  input  wire logic [31:0] unit_byte_addr,
  input  wire logic        err_single,
  input  wire logic        err_double,
  input  wire logic        clear_ecc_status_command,
  input  wire logic        soft_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] trapped_unit_address,
  output logic      [15:0] error_tally_value,
  output logic             irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    eet_mode_t               mode;
    eet_addr_t               trap;
    logic                    captured;
    eet_tally_t              tally;
    logic                    one_bit_only;
    logic [`EET_EV_W-1:0]    stat;
    logic [`EET_EV_W-1:0]    en;
    logic [31:0]             rdata;
    logic                    ready;
    logic                    slverr;
    logic                    irq;
  } eet_state_t;

  eet_state_t s_q;
  eet_state_t s_d;
  logic       log_error;
  logic [`EET_EV_W-1:0] ev;

  function automatic logic [31:0] unit_addr(input logic [31:0] a);
    unit_addr = {a[31:`EET_UNIT_LSB], {`EET_UNIT_LSB{1'b0}}};
  endfunction : unit_addr

  function automatic logic known_ofs(input logic [11:0] a);
    known_ofs = (a == `EET_OFS_ADDR) || (a == `EET_OFS_TALLY) ||
                (a == `EET_OFS_CTRL) || (a == `EET_OFS_CLEAR) ||
                (a == `EET_OFS_STAT) || (a == `EET_OFS_IRQCLR) ||
                (a == `EET_OFS_IRQEN);
  endfunction : known_ofs

  eet_error_qualify u_qual (
    .one_bit_only (s_q.one_bit_only),
    .unit_valid   (unit_valid),
    .err_single   (err_single),
    .err_double   (err_double),
    .in_read      (s_q.mode == EET_READ),
    .log_error    (log_error)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic clr;
    logic srst;
    wr   = 1'b0;
    rd   = 1'b0;
    clr  = 1'b0;
    srst = 1'b0;
    ev   = '0;
    s_d  = s_q;
    s_d.ready  = 1'b0;
    s_d.slverr = 1'b0;
    case (s_q.mode)
      EET_IDLE: if (read_active) s_d.mode = EET_READ;
      EET_READ: if (!read_active) s_d.mode = EET_IDLE;
      default:  s_d.mode = EET_IDLE;
    endcase
    if (psel && penable && !s_q.ready) begin
      s_d.ready  = 1'b1;
      s_d.slverr = !known_ofs(paddr);
      wr = pwrite;
      rd = !pwrite;
    end
    if (wr && paddr == `EET_OFS_CLEAR) begin
      clr  = pwdata[`EET_CLEAR_TRAP_BIT];
      srst = pwdata[`EET_CLEAR_SWRST_BIT];
    end
    if (log_error) begin
      if (!s_q.captured) begin
        s_d.trap     = unit_addr(unit_byte_addr);
        s_d.captured = 1'b1;
        ev[`EET_EV_TRAP_BIT] = 1'b1;
      end
      if (s_q.tally != `EET_TALLY_MAX) begin
        s_d.tally = s_q.tally + 16'h0001;
        ev[`EET_EV_COUNT_BIT] = 1'b1;
        if (s_q.tally == `EET_TALLY_MAX - 16'h0001) ev[`EET_EV_SAT_BIT] = 1'b1;
      end
    end
    if (clear_ecc_status_command || clr || srst || soft_reset) begin
      s_d.trap     = `EET_TRAP_RESET;
      s_d.captured = 1'b0;
    end
    if (srst || soft_reset) begin
      s_d.tally = `EET_TALLY_RESET;
    end
    if (wr && paddr == `EET_OFS_CTRL) s_d.one_bit_only = pwdata[`EET_CTRL_ONEBIT_BIT];
    if (wr && paddr == `EET_OFS_IRQEN) s_d.en = pwdata[`EET_EV_W-1:0];
    if (wr && paddr == `EET_OFS_IRQCLR) s_d.stat = s_q.stat & ~pwdata[`EET_EV_W-1:0];
    s_d.stat = s_d.stat | ev;
    if (rd) begin
      case (paddr)
        `EET_OFS_ADDR:  s_d.rdata = s_q.trap;
        `EET_OFS_TALLY: s_d.rdata = {16'h0000, s_q.tally};
        `EET_OFS_CTRL:  s_d.rdata = {31'h0, s_q.one_bit_only};
        `EET_OFS_STAT:  s_d.rdata = {29'h0, s_q.stat};
        `EET_OFS_IRQEN: s_d.rdata = {29'h0, s_q.en};
        default:        s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.irq = |(s_d.stat & s_d.en);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.mode         <= EET_IDLE;
      s_q.trap         <= `EET_TRAP_RESET;
      s_q.captured     <= 1'b0;
      s_q.tally        <= `EET_TALLY_RESET;
      s_q.one_bit_only <= 1'b0;
      s_q.stat         <= '0;
      s_q.en           <= '0;
      s_q.rdata        <= 32'h0000_0000;
      s_q.ready        <= 1'b0;
      s_q.slverr       <= 1'b0;
      s_q.irq          <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata               = s_q.rdata;
  assign pready               = s_q.ready;
  assign pslverr              = s_q.slverr;
  assign trapped_unit_address = s_q.trap;
  assign error_tally_value    = s_q.tally;
  assign irq                  = s_q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic        srst_w;
  logic        clr_w;
  logic [31:0] trap_q_w;
  assign srst_w   = soft_reset ||
                    (psel && penable && !s_q.ready && pwrite && paddr == `EET_OFS_CLEAR
                     && pwdata[`EET_CLEAR_SWRST_BIT]);
  assign clr_w    = psel && penable && !s_q.ready && pwrite && paddr == `EET_OFS_CLEAR
                    && pwdata[`EET_CLEAR_TRAP_BIT];
  assign trap_q_w = s_q.trap;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_trap_first_load: assert property (
    log_error && !s_q.captured && !clear_ecc_status_command && !srst_w && !clr_w
    |=> trap_q_w == {$past(unit_byte_addr[31:4]), 4'h0})
    else $error("trap not loaded on first error");
  chk_trap_hold: assert property (
    s_q.captured && !clear_ecc_status_command && !clr_w && !srst_w
    |=> $stable(trap_q_w))
    else $error("trap changed while captured");
  chk_trap_clear: assert property (
    clear_ecc_status_command |=> trap_q_w == 32'h0 && !s_q.captured)
    else $error("trap not cleared");
  chk_tally_only_read: assert property (
    s_q.mode != EET_READ && !srst_w |=> $stable(s_q.tally))
    else $error("tally changed outside read");
  chk_tally_step: assert property (
    !srst_w |=> (s_q.tally == $past(s_q.tally)) ||
                (s_q.tally == $past(s_q.tally) + 16'h1))
    else $error("tally moved by more than one");
  chk_tally_sat: assert property (
    s_q.tally == 16'hffff && !srst_w |=> s_q.tally == 16'hffff)
    else $error("tally left saturation");
  chk_onebit_mode: assert property (
    s_q.one_bit_only && !err_single |-> !log_error)
    else $error("double error logged in single mode");
  chk_tally_count: assert property (
    log_error && s_q.tally != 16'hffff && !srst_w |=> s_q.tally == $past(s_q.tally) + 16'h1)
    else $error("tally missed an error");
  chk_swrst_tally: assert property (
    srst_w |=> s_q.tally == 16'h0)
    else $error("tally not reset");

  cov_first_trap: cover property (log_error && !s_q.captured);
  cov_saturate:   cover property (s_q.tally == 16'hfffe ##1 s_q.tally == 16'hffff);
  cov_irq:        cover property (!irq ##1 irq);
endmodule : eet_trap
`default_nettype wire
